// ### pdseq_defines.vh
// How it works
// RL1 - Powerdown is entered only when the powerdown request bit is 1 and a halt instruction executes.
// RL2 - In powerdown, an interrupt from the non-maskable input or an asserted reset input ends powerdown.
// RL3 - A wake by the non-maskable input waits the wake delay before clocks are re-enabled.
// RL4 - A wake by reset skips the wake delay entirely.
// RL5 - Asserting the reset input aborts any bus cycle at once and initialises the logic; the code does so on the third clock edge after the pin falls.
// RL6 - During reset every output is driven to a defined level and the reset output is raised.
// RL7 - An assertion of the non-maskable input is latched so that a short pulse is not lost.
// RL8 - The reset output stays high for as long as the reset input is low.
// RL9 - The wake delay is modelled as a configurable count of clock cycles.
`ifndef PDSEQ_DEFINES_VH
`define PDSEQ_DEFINES_VH
`define WAKE_DELAY_NS 10000
`define CLK_PERIOD_NS 10
`define WAKE_DELAY_CYCLES (`WAKE_DELAY_NS / `CLK_PERIOD_NS)
`define WAKE_CNT_WIDTH 20
`define RESET_PIN_RST 1'h0
`define NMI_PIN_RST 1'h0
`define RESET_OUT_RST 1'h1
`define BUS_ABORT_RST 1'h1
`define CLOCKS_EN_RST 1'h1
`define IN_PDOWN_RST 1'h0
`define NMI_PEND_RST 1'h0
`endif

// ### powerdown_reset_sequencer.v
`timescale 1ns/1ps
`include "pdseq_defines.vh"

// Two-flop synchroniser for one pin; only the second flop is visible outside
module pin_sync #(
	parameter [0:0] RST_VAL = 1'h0
) (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Raw pin and its synchronised copy
	input wire pin,
	output reg synced
);
	reg meta;

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= RST_VAL;
			synced <= RST_VAL;
		end else begin
			meta <= pin;
			synced <= meta;
		end
	end
endmodule

module powerdown_reset_sequencer #(
	parameter WAKE_CYCLES = `WAKE_DELAY_CYCLES,
	parameter CNT_W = `WAKE_CNT_WIDTH
) (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// External pins
	input wire reset_in_n,
	input wire nmi_in,
	// Core side
	input wire powerdown_request_bit,
	input wire halt_exec,
	input wire nmi_taken,
	// Status outputs
	output reg reset_out,
	output reg clocks_enabled,
	output reg in_powerdown,
	output reg bus_abort,
	output reg nmi_pending
);
	// One-hot sequencer states
	localparam [2:0] ST_RUN = 3'h1;
	localparam [2:0] ST_PDOWN = 3'h2;
	localparam [2:0] ST_WAKE = 3'h4;

	// Counter constants, cut to the counter width on purpose
	localparam [CNT_W-1:0] WAKE_LOAD = WAKE_CYCLES[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};

	// Synchronised pins
	wire reset_pin_s;
	wire nmi_pin_s;

	// Decoded events
	reg nmi_prev;
	wire nmi_edge;
	wire rst_active;
	wire halt_accept;
	wire wake_start;
	wire wake_done;

	// Sequencer state and next values
	reg [2:0] state;
	reg [2:0] next_state;
	reg [CNT_W-1:0] wake_cnt;
	reg [CNT_W-1:0] next_wake_cnt;
	reg next_nmi_pending;
	reg next_clocks_enabled;
	reg next_in_powerdown;

	// The reset pin reads as asserted until its real level has passed both
	// flops, so the core never runs on a half-settled reset after sys_rst
	pin_sync #(
		.RST_VAL(`RESET_PIN_RST)
	) reset_pin_sync_i (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin(reset_in_n),
		.synced(reset_pin_s)
	);

	// Idle level of the interrupt pin, so no false edge follows sys_rst
	pin_sync #(
		.RST_VAL(`NMI_PIN_RST)
	) nmi_pin_sync_i (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin(nmi_in),
		.synced(nmi_pin_s)
	);

	assign rst_active = ~reset_pin_s;
	assign nmi_edge = nmi_pin_s & ~nmi_prev;
	assign halt_accept = (state == ST_RUN) & halt_exec & powerdown_request_bit; // see RL1
	assign wake_start = (state == ST_PDOWN) & (nmi_pending | nmi_edge); // see RL2
	assign wake_done = (state == ST_WAKE) & (wake_cnt == CNT_ZERO); // see RL3

	// Previous synchronised level for the rising-edge detector
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			nmi_prev <= `NMI_PIN_RST;
		end else begin
			nmi_prev <= nmi_pin_s;
		end
	end

	// Next state; halts during powerdown or wake are simply ignored
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (halt_accept)
					next_state = ST_PDOWN; // see RL1
			end
			ST_PDOWN: begin
				if (wake_start)
					next_state = ST_WAKE; // see RL2
			end
			ST_WAKE: begin
				if (wake_done)
					next_state = ST_RUN; // see RL3
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// Wake delay counter; the capacitor charge time becomes a cycle count
	always @* begin
		next_wake_cnt = wake_cnt;
		if (wake_start)
			next_wake_cnt = WAKE_LOAD; // see RL9
		else if ((state == ST_WAKE) && (wake_cnt != CNT_ZERO))
			next_wake_cnt = wake_cnt - CNT_ONE; // see RL3
	end

	// Interrupt latch: a new edge beats an acknowledge in the same cycle
	always @* begin
		next_nmi_pending = nmi_pending;
		if (nmi_edge)
			next_nmi_pending = 1'h1; // see RL7
		else if (nmi_taken)
			next_nmi_pending = 1'h0;
	end

	// Output levels follow the state that is about to be entered
	always @* begin
		next_clocks_enabled = (next_state == ST_RUN);
		next_in_powerdown = (next_state != ST_RUN);
	end

	// State register; reset leaves powerdown straight to run, see RL2 see RL4
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_RUN;
		end else if (rst_active) begin
			state <= ST_RUN; // see RL5
		end else begin
			state <= next_state;
		end
	end

	// Counter register; cleared by reset so no delay is applied, see RL4
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_cnt <= CNT_ZERO;
		end else if (rst_active) begin
			wake_cnt <= CNT_ZERO;
		end else begin
			wake_cnt <= next_wake_cnt;
		end
	end

	// Latched interrupt; an edge during reset is dropped with the rest of the state
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			nmi_pending <= `NMI_PEND_RST;
		end else if (rst_active) begin
			nmi_pending <= `NMI_PEND_RST;
		end else begin
			nmi_pending <= next_nmi_pending;
		end
	end

	// Reset indicators stay up for as long as the pin is held low
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_out <= `RESET_OUT_RST;
			bus_abort <= `BUS_ABORT_RST;
		end else if (rst_active) begin
			reset_out <= 1'h1; // see RL6 see RL8
			bus_abort <= 1'h1; // see RL5
		end else begin
			reset_out <= 1'h0;
			bus_abort <= 1'h0;
		end
	end

	// Clock and powerdown status, driven to known levels in reset, see RL6
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clocks_enabled <= `CLOCKS_EN_RST;
			in_powerdown <= `IN_PDOWN_RST;
		end else if (rst_active) begin
			clocks_enabled <= 1'h1; // see RL4
			in_powerdown <= 1'h0;
		end else begin
			clocks_enabled <= next_clocks_enabled;
			in_powerdown <= next_in_powerdown;
		end
	end
endmodule

// ### pdseq_assertions.sv
`timescale 1ns/1ps
module pdseq_check(input wire mclk, sys_rst, reset_in_n, nmi_in, powerdown_request_bit, halt_exec,
	reset_out, clocks_enabled, in_powerdown, bus_abort, nmi_pending);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_halt_refused: assert property (!in_powerdown && halt_exec && !powerdown_request_bit |=> !in_powerdown)
		else $error("entry");
	a_halt_taken: assert property (!in_powerdown && !reset_out && halt_exec && powerdown_request_bit |=>
		(in_powerdown && !clocks_enabled) || reset_out) else $error("no entry");
	a_sleep_holds: assert property (in_powerdown && !nmi_pending |=> in_powerdown || reset_out)
		else $error("early exit");
	a_wake_delay: assert property ($rose(nmi_pending) && in_powerdown && !reset_out |=> (!clocks_enabled || reset_out)[*3])
		else $error("short delay");
	a_reset_wake: assert property (in_powerdown && !reset_in_n |-> ##[1:3] clocks_enabled) else $error("reset wake");
	a_abort_bus: assert property (reset_out |-> bus_abort) else $error("abort");
	a_nmi_latch: assert property ($rose(nmi_in) && !reset_out |-> ##3 nmi_pending) else $error("lost nmi");
	a_reset_out: assert property (!reset_in_n[*3] |=> reset_out) else $error("reset out");
	cover property ($rose(in_powerdown));
	cover property ($fell(in_powerdown) && !reset_out);
	cover property ($rose(reset_out) && $past(in_powerdown));
endmodule
bind powerdown_reset_sequencer pdseq_check pdseq_check_i(.*);

// ### pdseq_far.sv
`timescale 1ns/1ps
module pdseq_far(input wire mclk, output logic reset_in_n = 1'b1, output logic nmi_in = 1'b0);
	// One-cycle pulse: short enough that only a latch catches it
	task nmi_pulse;
		@(negedge mclk) nmi_in = 1'b1;
		@(negedge mclk) nmi_in = 1'b0;
	endtask
	task rst_hold(input int n);
		@(negedge mclk) reset_in_n = 1'b0;
		repeat (n) @(negedge mclk);
		reset_in_n = 1'b1;
	endtask
endmodule

// ### tb_powerdown_reset_sequencer.sv
`timescale 1ns/1ps
module tb_powerdown_reset_sequencer;
	logic mclk = 1'b0, sys_rst = 1'b1, powerdown_request_bit = 1'b0, halt_exec = 1'b0, nmi_taken = 1'b0;
	wire reset_in_n, nmi_in, reset_out, clocks_enabled, in_powerdown, bus_abort, nmi_pending;
	int mismatches = 0, cmp_count = 0, n;
	initial forever #5 mclk = ~mclk;
	pdseq_far pdseq_far_i(.*);
	powerdown_reset_sequencer #(.WAKE_CYCLES(4)) powerdown_reset_sequencer_i(.*);
	task report_and_stop;
		if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: output mismatch", $time);
		end
	endtask
	task halt(input logic b);
		@(negedge mclk) powerdown_request_bit = b;
		halt_exec = 1'b1;
		@(negedge mclk) halt_exec = 1'b0;
	endtask
	task t_refuse;
		halt(1'b0);
		chk(in_powerdown, 1'b0);
	endtask
	task t_nmi_wake;
		halt(1'b1);
		chk(in_powerdown, 1'b1);
		chk(clocks_enabled, 1'b0);
		pdseq_far_i.nmi_pulse;
		for (n = 0; clocks_enabled !== 1'b1 && n < 50; n++) @(negedge mclk);
		if (n == 50) begin
			mismatches++;
			report_and_stop;
		end
		// Three latch edges, then WAKE_CYCLES+1 count edges, one already gone
		chk(n == 7, 1'b1);
		chk(in_powerdown, 1'b0);
		chk(nmi_pending, 1'b1);
		@(negedge mclk) nmi_taken = 1'b1;
		@(negedge mclk) nmi_taken = 1'b0;
		chk(nmi_pending, 1'b0);
	endtask
	task t_rst_wake;
		halt(1'b1);
		chk(in_powerdown, 1'b1);
		pdseq_far_i.rst_hold(5);
		chk(reset_out & bus_abort & clocks_enabled & ~in_powerdown, 1'b1);
		repeat (3) @(negedge mclk);
		chk(reset_out | bus_abort | ~clocks_enabled, 1'b0);
	endtask
	initial begin
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		t_refuse;
		t_nmi_wake;
		t_rst_wake;
		report_and_stop;
	end
endmodule
